/* File: kshd_map.svh */
// Register offsets, reset values and field positions for the key-sense and host data ports.
// Assumes inclusion by the package and by the design files that decode the APB address.
`ifndef KSHD_MAP_SVH
`define KSHD_MAP_SVH
`define KSHD_OFS_PA_OUT 16'hFFAA
`define KSHD_OFS_PA_DIR 16'hFFAB
`define KSHD_OFS_PB_OUT 16'hFFBC
`define KSHD_OFS_PB_PIN 16'hFFBD
`define KSHD_OFS_PB_DIR 16'hFFBE
`define KSHD_OFS_CTRL 16'hFFC4
`define KSHD_OFS_STAT 16'hFFC8
`define KSHD_RST_BYTE 8'h00
`define KSHD_CTRL_TWS 0
`define KSHD_CTRL_HIE 1
`define KSHD_CTRL_HWSTBY 2
`define KSHD_CTRL_SWSTBY 3
`define KSHD_MODE_LO 4
`define KSHD_MODE_HI 5
`define KSHD_CTRL_MASK 32'h0000003F
`define KSHD_CTRL_RST 6'h30
`endif

/* File: kshd_pkg.sv */
// Types shared by the port block and its pin stage.
// Assumes the map header lies in the include path.
`include "kshd_map.svh"
package kshd_pkg;
    typedef logic [7:0] kshd_byte_t;
    typedef enum logic [1:0] {
        KSHD_MODE1 = 2'h1,
        KSHD_MODE2 = 2'h2,
        KSHD_MODE3 = 2'h3
    } kshd_mode_e;
    typedef struct packed {
        kshd_byte_t dout;
        kshd_byte_t oe;
        kshd_byte_t pull;
    } kshd_pin_drive_s;
    // Field order puts the mode in bits 5:4 and the two-wire select in bit 0.
    typedef struct packed {
        kshd_mode_e mode;
        logic sw_standby;
        logic hw_standby;
        logic host_port_enable;
        logic twowire_buffer_select;
    } kshd_ctrl_s;
endpackage

/* File: kshd_pin_sync.sv */
// Two-stage synchroniser for an eight-bit group of pin levels.
// Assumes the pins are asynchronous to pclk.
`timescale 1ns/1ps
`default_nettype none
module kshd_pin_sync
    import kshd_pkg::*;
(
    input wire logic pclk, // System clock.
    input wire logic presetn, // Asynchronous reset, active low.
    input wire logic [7:0] pin_in, // Raw pin levels.
    output logic [7:0] pin_sync // Synchronised pin levels.
);
    logic [7:0] meta_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_r <= `KSHD_RST_BYTE;
            pin_sync <= `KSHD_RST_BYTE;
        end else begin
            meta_r <= pin_in;
            pin_sync <= meta_r;
        end
    end
endmodule
`default_nettype wire

/* File: kshd_ports.sv */
// Key-sense port and host data port: registers, pin drivers, pull-ups, APB slave.
// Assumes an APB master on pclk; pins and port-seven levels are asynchronous inputs.
`timescale 1ns/1ps
`default_nettype none
module kshd_ports
    import kshd_pkg::*;
(
    input wire logic pclk, // System clock, 100 MHz.
    input wire logic presetn, // Asynchronous reset, active low.
    input wire logic psel, // APB select.
    input wire logic penable, // APB access phase.
    input wire logic pwrite, // APB write.
    input wire logic [15:0] paddr, // APB byte address.
    input wire logic [31:0] pwdata, // APB write data.
    output logic [31:0] prdata, // APB read data.
    output logic pready, // APB ready.
    output logic pslverr, // APB error for unmapped address.
    input wire logic [7:0] pa_pin_i, // Port A pin levels.
    output logic [7:0] pa_pin_o, // Port A output level.
    output logic [7:0] pa_pin_oe, // Port A output enable.
    output logic [7:0] pa_pullup_en, // Port A pull-up enable.
    output logic [3:0] pa_bus_buffer_en, // Pins 7..4 in bus-buffer drive.
    output logic [7:0] key_sense_input, // Key-sense levels.
    input wire logic [7:0] pb_pin_i, // Port B pin levels.
    output logic [7:0] pb_pin_o, // Port B output level.
    output logic [7:0] pb_pin_oe, // Port B output enable.
    output logic [7:0] pb_pullup_en, // Port B pull-up enable.
    output logic host_data_bus_sel, // Port B handed to host data bus.
    input wire logic [7:0] port_seven_pin_i // Port seven pin levels.
);
    kshd_byte_t porta_output_latch_r, porta_direction_r;
    kshd_byte_t portb_output_latch_r, portb_direction_r;
    kshd_ctrl_s ctrl_r;
    kshd_byte_t pa_sync, pb_sync, p7_sync;
    kshd_pin_drive_s pa_drv, pb_drv;
    kshd_byte_t pb_pull_nxt;
    logic wr_en, rd_en, addr_ok, hw_clr, slave_mode;
    logic [31:0] rdata_nxt;

    // A write is taken on the access-phase edge and a read on the setup-phase edge; the slave never waits.
    function automatic logic is_mapped(input logic [15:0] a);
        case (a)
            `KSHD_OFS_PA_OUT, `KSHD_OFS_PA_DIR, `KSHD_OFS_PB_OUT, `KSHD_OFS_PB_PIN,
            `KSHD_OFS_PB_DIR, `KSHD_OFS_CTRL, `KSHD_OFS_STAT: is_mapped = 1'b1;
            default: is_mapped = 1'b0;
        endcase
    endfunction

    // Pull-up is on only for an input pin whose latch bit is one.
    function automatic kshd_byte_t pull_of(input kshd_byte_t lat, input kshd_byte_t dir);
        pull_of = lat & ~dir;
    endfunction

    kshd_pin_sync u_sync_pa (
        .pclk(pclk),
        .presetn(presetn),
        .pin_in(pa_pin_i),
        .pin_sync(pa_sync)
    );
    kshd_pin_sync u_sync_pb (
        .pclk(pclk),
        .presetn(presetn),
        .pin_in(pb_pin_i),
        .pin_sync(pb_sync)
    );
    kshd_pin_sync u_sync_p7 (
        .pclk(pclk),
        .presetn(presetn),
        .pin_in(port_seven_pin_i),
        .pin_sync(p7_sync)
    );

    assign addr_ok = is_mapped(paddr);
    assign wr_en = psel && penable && pwrite && addr_ok;
    assign rd_en = psel && !pwrite;
    assign hw_clr = ctrl_r.hw_standby;
    assign slave_mode = ctrl_r.host_port_enable && (ctrl_r.mode != KSHD_MODE3);

    // Hardware standby clears the port registers like a reset; software standby keeps them.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            porta_direction_r <= `KSHD_RST_BYTE;
        end else if (hw_clr) begin
            porta_direction_r <= `KSHD_RST_BYTE;
        end else if (wr_en && paddr == `KSHD_OFS_PA_DIR) begin
            porta_direction_r <= pwdata[7:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            porta_output_latch_r <= `KSHD_RST_BYTE;
        end else if (hw_clr) begin
            porta_output_latch_r <= `KSHD_RST_BYTE;
        end else if (wr_en && paddr == `KSHD_OFS_PA_OUT) begin
            porta_output_latch_r <= pwdata[7:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            portb_direction_r <= `KSHD_RST_BYTE;
        end else if (hw_clr) begin
            portb_direction_r <= `KSHD_RST_BYTE;
        end else if (wr_en && paddr == `KSHD_OFS_PB_DIR) begin
            portb_direction_r <= pwdata[7:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            portb_output_latch_r <= `KSHD_RST_BYTE;
        end else if (hw_clr) begin
            portb_output_latch_r <= `KSHD_RST_BYTE;
        end else if (wr_en && paddr == `KSHD_OFS_PB_OUT) begin
            portb_output_latch_r <= pwdata[7:0];
        end
    end

    // Control holds the two-wire select, host enable, standby states and operating mode.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r <= kshd_ctrl_s'(`KSHD_CTRL_RST);
        end else if (wr_en && paddr == `KSHD_OFS_CTRL) begin
            ctrl_r <= kshd_ctrl_s'(pwdata[`KSHD_MODE_HI:0]);
            if (pwdata[`KSHD_MODE_HI:`KSHD_MODE_LO] == 2'h0) begin
                ctrl_r.mode <= ctrl_r.mode;
            end
        end
    end

    // Port A drive is the same in every mode; output when the direction bit is one.
    always_comb begin
        pa_drv.dout = porta_output_latch_r;
        pa_drv.oe = porta_direction_r;
        pa_drv.pull = pull_of(porta_output_latch_r, porta_direction_r);
        pb_drv.dout = portb_output_latch_r;
        pb_drv.oe = slave_mode ? `KSHD_RST_BYTE : portb_direction_r;
        pb_drv.pull = pull_of(portb_output_latch_r, portb_direction_r);
        // In software standby the port B pull-ups freeze at their previous state.
        pb_pull_nxt = ctrl_r.sw_standby ? pb_pullup_en : pb_drv.pull;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pa_pin_o <= `KSHD_RST_BYTE;
            pa_pin_oe <= `KSHD_RST_BYTE;
            pb_pin_o <= `KSHD_RST_BYTE;
            pb_pin_oe <= `KSHD_RST_BYTE;
            host_data_bus_sel <= 1'b0;
            pa_bus_buffer_en <= 4'h0;
        end else begin
            pa_pin_o <= pa_drv.dout;
            pa_pin_oe <= pa_drv.oe;
            pb_pin_o <= pb_drv.dout;
            pb_pin_oe <= pb_drv.oe;
            host_data_bus_sel <= slave_mode;
            pa_bus_buffer_en <= {4{ctrl_r.twowire_buffer_select}};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pa_pullup_en <= `KSHD_RST_BYTE;
            pb_pullup_en <= `KSHD_RST_BYTE;
        end else if (hw_clr) begin
            pa_pullup_en <= `KSHD_RST_BYTE;
            pb_pullup_en <= `KSHD_RST_BYTE;
        end else begin
            pa_pullup_en <= pa_drv.pull;
            pb_pullup_en <= pb_pull_nxt;
        end
    end

    // Key-sense sees the pin level whatever the direction.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            key_sense_input <= `KSHD_RST_BYTE;
        end else begin
            key_sense_input <= pa_sync;
        end
    end

    always_comb begin
        rdata_nxt = 32'h00000000;
        case (paddr)
            `KSHD_OFS_PA_OUT: rdata_nxt[7:0] = porta_output_latch_r;
            `KSHD_OFS_PA_DIR: rdata_nxt[7:0] = pa_sync;
            `KSHD_OFS_PB_OUT: rdata_nxt[7:0] = portb_output_latch_r;
            `KSHD_OFS_PB_PIN: rdata_nxt[7:0] = pb_sync;
            `KSHD_OFS_PB_DIR: rdata_nxt[7:0] = p7_sync;
            `KSHD_OFS_CTRL: rdata_nxt = {26'h0000000, ctrl_r};
            `KSHD_OFS_STAT: rdata_nxt = {8'h00, porta_direction_r, portb_direction_r,
                                         7'h00, slave_mode};
            default: rdata_nxt = 32'h00000000;
        endcase
    end

    // Setup cycle registers the answer so it stands during the access phase.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !addr_ok;
            if (rd_en && !penable) begin
                prdata <= rdata_nxt;
            end
        end
    end

    a_pa_dir_write: assert property (@(posedge pclk) disable iff (!presetn)
        wr_en && paddr == `KSHD_OFS_PA_DIR && !hw_clr |=> porta_direction_r == $past(pwdata[7:0]))
        else $error("port A direction write lost");
    a_pa_oe_follow: assert property (@(posedge pclk) disable iff (!presetn)
        pa_pin_oe == $past(porta_direction_r))
        else $error("port A enable does not follow direction");
    a_pa_pull_rule: assert property (@(posedge pclk) disable iff (!presetn)
        !$past(hw_clr) |-> pa_pullup_en == ($past(porta_output_latch_r) & ~$past(porta_direction_r)))
        else $error("port A pull-up wrong");
    a_hw_pull_off: assert property (@(posedge pclk) disable iff (!presetn)
        hw_clr |=> pa_pullup_en == 8'h00 && pb_pullup_en == 8'h00)
        else $error("pull-ups on in hardware standby");
    a_hw_dir_clr: assert property (@(posedge pclk) disable iff (!presetn)
        hw_clr |=> porta_direction_r == 8'h00 && portb_direction_r == 8'h00)
        else $error("direction not cleared in hardware standby");
    a_sw_pull_hold: assert property (@(posedge pclk) disable iff (!presetn)
        ctrl_r.sw_standby && !hw_clr |=> $stable(pb_pullup_en))
        else $error("port B pull-up changed in software standby");
    a_slave_no_drive: assert property (@(posedge pclk) disable iff (!presetn)
        slave_mode |=> pb_pin_oe == 8'h00 && host_data_bus_sel)
        else $error("port B driven in slave mode");
    a_pb_dir_read: assert property (@(posedge pclk) disable iff (!presetn)
        psel && !penable && !pwrite && paddr == `KSHD_OFS_PB_DIR
        |=> prdata == {24'h000000, $past(p7_sync)})
        else $error("port B direction read not port seven");
    a_bb_follow: assert property (@(posedge pclk) disable iff (!presetn)
        ctrl_r.twowire_buffer_select |=> pa_bus_buffer_en == 4'hF)
        else $error("bus buffer not enabled");

    // The checks below tie the port latch and direction registers, the pin and latch reads and the pin drives to their sources.

    a_pa_lat_write: assert property (@(posedge pclk) disable iff (!presetn)
        wr_en && paddr == `KSHD_OFS_PA_OUT && !hw_clr
        |=> porta_output_latch_r == $past(pwdata[7:0]))
        else $error("port A latch write lost");

    a_pb_lat_write: assert property (@(posedge pclk) disable iff (!presetn)
        wr_en && paddr == `KSHD_OFS_PB_OUT && !hw_clr
        |=> portb_output_latch_r == $past(pwdata[7:0]))
        else $error("port B latch write lost");

    a_pb_dir_write: assert property (@(posedge pclk) disable iff (!presetn)
        wr_en && paddr == `KSHD_OFS_PB_DIR && !hw_clr
        |=> portb_direction_r == $past(pwdata[7:0]))
        else $error("port B direction write lost");

    a_hw_lat_clr: assert property (@(posedge pclk) disable iff (!presetn)
        hw_clr |=> porta_output_latch_r == 8'h00 && portb_output_latch_r == 8'h00)
        else $error("latch not cleared in hardware standby");

    a_pa_pin_read: assert property (@(posedge pclk) disable iff (!presetn)
        psel && !penable && !pwrite && paddr == `KSHD_OFS_PA_DIR
        |=> prdata == {24'h000000, $past(pa_sync)})
        else $error("port A pin read wrong");

    a_pb_pin_read: assert property (@(posedge pclk) disable iff (!presetn)
        psel && !penable && !pwrite && paddr == `KSHD_OFS_PB_PIN
        |=> prdata == {24'h000000, $past(pb_sync)})
        else $error("port B pin read wrong");

    a_pa_lat_read: assert property (@(posedge pclk) disable iff (!presetn)
        psel && !penable && !pwrite && paddr == `KSHD_OFS_PA_OUT
        |=> prdata == {24'h000000, $past(porta_output_latch_r)})
        else $error("port A latch read wrong");

    a_pb_lat_read: assert property (@(posedge pclk) disable iff (!presetn)
        psel && !penable && !pwrite && paddr == `KSHD_OFS_PB_OUT
        |=> prdata == {24'h000000, $past(portb_output_latch_r)})
        else $error("port B latch read wrong");

    a_ks_follow: assert property (@(posedge pclk) disable iff (!presetn)
        key_sense_input == $past(pa_sync))
        else $error("key-sense does not follow pins");

    a_pb_oe_gpio: assert property (@(posedge pclk) disable iff (!presetn)
        !slave_mode |=> pb_pin_oe == $past(portb_direction_r) && !host_data_bus_sel)
        else $error("port B not general I/O outside slave mode");

    a_pb_oe_mode3: assert property (@(posedge pclk) disable iff (!presetn)
        ctrl_r.mode == KSHD_MODE3 |=> pb_pin_oe == $past(portb_direction_r))
        else $error("port B enable wrong in mode three");

    a_pb_pull_rule: assert property (@(posedge pclk) disable iff (!presetn)
        !ctrl_r.sw_standby && !hw_clr
        |=> pb_pullup_en == ($past(portb_output_latch_r) & ~$past(portb_direction_r)))
        else $error("port B pull-up wrong");

    a_bb_off: assert property (@(posedge pclk) disable iff (!presetn)
        !ctrl_r.twowire_buffer_select |=> pa_bus_buffer_en == 4'h0)
        else $error("bus buffer on while not selected");

    a_pa_out_follow: assert property (@(posedge pclk) disable iff (!presetn)
        pa_pin_o == $past(porta_output_latch_r))
        else $error("port A output does not follow latch");

    a_pb_out_follow: assert property (@(posedge pclk) disable iff (!presetn)
        pb_pin_o == $past(portb_output_latch_r))
        else $error("port B output does not follow latch");

    a_sw_dir_keep: assert property (@(posedge pclk) disable iff (!presetn)
        ctrl_r.sw_standby && !hw_clr && !wr_en
        |=> $stable(porta_direction_r) && $stable(portb_direction_r))
        else $error("direction changed in software standby");

    a_ready_access: assert property (@(posedge pclk) disable iff (!presetn)
        psel && !penable |=> pready)
        else $error("ready missing in access phase");

    a_err_unmapped: assert property (@(posedge pclk) disable iff (!presetn)
        psel && !penable && !addr_ok |=> pslverr && pready)
        else $error("no error for unmapped address");

    c_pa_write: cover property (@(posedge pclk) disable iff (!presetn)
        wr_en && paddr == `KSHD_OFS_PA_DIR);
    c_slave: cover property (@(posedge pclk) disable iff (!presetn) slave_mode);
    c_sw_stby: cover property (@(posedge pclk) disable iff (!presetn)
        ctrl_r.sw_standby && pb_pullup_en != 8'h00);
    c_hw_stby: cover property (@(posedge pclk) disable iff (!presetn) hw_clr);
    c_bus_buffer: cover property (@(posedge pclk) disable iff (!presetn)
        ctrl_r.twowire_buffer_select);
endmodule
`default_nettype wire

/* File: kshd_pin_model.sv */
// Pin model for port A and port B: on-chip drivers, pull-ups and outside sources.
// Assumes the testbench gives outside levels and a mask of the bits it drives.
`timescale 1ns/1ps
`default_nettype none
module kshd_pin_model
    import kshd_pkg::*;
(
    input wire logic pclk, // Clock for the floating pattern.
    input wire kshd_pin_drive_s pa_drv, // Port A drive, enable and pull-up.
    input wire kshd_pin_drive_s pb_drv, // Port B drive, enable and pull-up.
    input wire logic [15:0] ext_val, // Outside levels, port B in the high byte.
    input wire logic [15:0] ext_en, // Outside drive mask, port B in the high byte.
    output logic [7:0] pa_lvl, // Resolved port A levels.
    output logic [7:0] pb_lvl // Resolved port B levels.
);
    logic flt_r = 1'b0;
    // A pin with no driver and no pull-up shows a level that flips every cycle.
    always @(posedge pclk) begin
        flt_r <= ~flt_r;
    end
    function automatic logic [7:0] res(kshd_pin_drive_s d, logic [7:0] v, logic [7:0] e,
                                       logic f);
        res = (d.oe & d.dout) | (~d.oe & e & v) | (~d.oe & ~e & d.pull)
            | (~d.oe & ~e & ~d.pull & {8{f}});
    endfunction
    assign pa_lvl = res(pa_drv, ext_val[7:0], ext_en[7:0], flt_r);
    assign pb_lvl = res(pb_drv, ext_val[15:8], ext_en[15:8], flt_r);
endmodule
`default_nettype wire

/* File: tb_keysense_and_host_data_ports.sv */
// Self-checking testbench for the key-sense and host data ports over APB.
// Assumes the port block, its package and the pin model are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "kshd_map.svh"
module tb_keysense_and_host_data_ports;
    import kshd_pkg::*;
    localparam logic [15:0] AO = `KSHD_OFS_PA_OUT, AD = `KSHD_OFS_PA_DIR;
    localparam logic [15:0] BO = `KSHD_OFS_PB_OUT, BP = `KSHD_OFS_PB_PIN;
    localparam logic [15:0] BD = `KSHD_OFS_PB_DIR, CT = `KSHD_OFS_CTRL;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [15:0] paddr = 16'h0000, ext_val = 16'h0350, ext_en = 16'h0FF0;
    logic [31:0] pwdata = 32'h0000_0000, prdata;
    logic pready, pslverr, host_data_bus_sel;
    logic [7:0] pa_pin_i, pa_pin_o, pa_pin_oe, pa_pullup_en, key_sense_input;
    logic [7:0] pb_pin_i, pb_pin_o, pb_pin_oe, pb_pullup_en, p7 = 8'h9A;
    logic [3:0] pa_bus_buffer_en;
    logic [31:0] rd;
    logic er;
    int mismatches = 0, checked = 0;
    always #5 pclk = ~pclk;
    kshd_ports u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pa_pin_i(pa_pin_i), .pa_pin_o(pa_pin_o), .pa_pin_oe(pa_pin_oe),
        .pa_pullup_en(pa_pullup_en), .pa_bus_buffer_en(pa_bus_buffer_en),
        .key_sense_input(key_sense_input), .pb_pin_i(pb_pin_i), .pb_pin_o(pb_pin_o),
        .pb_pin_oe(pb_pin_oe), .pb_pullup_en(pb_pullup_en),
        .host_data_bus_sel(host_data_bus_sel), .port_seven_pin_i(p7));
    kshd_pin_model u_pins (.pclk(pclk), .pa_drv({pa_pin_o, pa_pin_oe, pa_pullup_en}),
        .pb_drv({pb_pin_o, pb_pin_oe, pb_pullup_en}), .ext_val(ext_val), .ext_en(ext_en),
        .pa_lvl(pa_pin_i), .pb_lvl(pb_pin_i));
    task automatic final_report();
        $display("mismatches=%0d checked=%0d", mismatches, checked);
        if (mismatches == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // One APB transfer; the request is held until pready is seen at a rising edge.
    task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) begin
            mismatches++;
            final_report();
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        apb(1'b1, a, {24'h000000, d});
    endtask
    task automatic rdc(input logic [15:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        chk(rd, exp);
    endtask
    // Pins and pull-ups land one cycle after a write, key-sense levels need three more.
    task automatic settle();
        repeat (6) @(posedge pclk);
    endtask
    initial begin
        repeat (15) @(posedge pclk);
        chk(pa_pullup_en, 8'h00);
        @(posedge pclk);
        presetn <= 1'b1;
        rdc(AO, 32'h0);
        rdc(BO, 32'h0);
        rdc(`KSHD_OFS_STAT, 32'h0);
        wr(AO, 8'hA5);
        wr(AD, 8'h0F);
        wr(BO, 8'h3C);
        wr(BD, 8'hF0);
        settle();
        chk(pa_pin_oe, 8'h0F);
        chk(pa_pin_o & pa_pin_oe, 8'h05);
        chk(pa_pullup_en, 8'hA0);
        rdc(AD, 32'h55);
        rdc(AO, 32'hA5);
        chk(pb_pin_o & pb_pin_oe, 8'h30);
        chk(pb_pullup_en, 8'h0C);
        rdc(BP, 32'h33);
        rdc(BD, 32'h9A);
        for (int m = 1; m <= 3; m++) begin
            wr(CT, 8'(m * 16));
            settle();
            chk(pa_pin_oe, 8'h0F);
            chk(key_sense_input, 8'h55);
            chk({host_data_bus_sel, pb_pin_oe}, 9'h0F0);
        end
        wr(CT, 8'h31);
        settle();
        chk(pa_bus_buffer_en, 4'hF);
        wr(CT, 8'h38);
        wr(BD, 8'h00);
        settle();
        chk(pb_pullup_en, 8'h0C);
        chk(pa_pin_oe, 8'h0F);
        wr(CT, 8'h30);
        settle();
        chk({pa_bus_buffer_en, pb_pullup_en}, 12'h03C);
        for (int m = 1; m <= 2; m++) begin
            wr(BD, 8'hFF);
            wr(CT, 8'(m * 16 + 2));
            settle();
            chk({host_data_bus_sel, pb_pin_oe}, 9'h100);
            wr(BO, 8'h00);
            wr(BD, 8'h00);
        end
        wr(CT, 8'h32);
        wr(BO, 8'hFF);
        settle();
        chk({host_data_bus_sel, pb_pullup_en}, 9'h0FF);
        wr(CT, 8'h34);
        settle();
        chk({pa_pullup_en, pb_pullup_en}, 16'h0000);
        wr(CT, 8'h30);
        settle();
        chk(pa_pin_oe, 8'h00);
        rdc(AO, 32'h0);
        rdc(BO, 32'h0);
        apb(1'b0, 16'hFF00, 32'h0);
        chk(er, 1'b1);
        chk(rd, 32'h0);
        final_report();
    end
endmodule
`default_nettype wire
